// File: fpc_pkg.sv
package fpc_pkg;

  // ==========================================================
  // Clock and pin timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int READ_ACCESS_NS     = 100;
  localparam int WE_LOW_NS          = 70;
  localparam int WE_HIGH_NS         = 30;
  localparam int POWERDOWN_RECOVERY_NS = 150;
  localparam int SYNC_STAGES        = 3;
  localparam int READ_CYC     = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int WE_LOW_CYC   = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC  = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (POWERDOWN_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Widths and flash constants
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int TMR_W  = 8;
  localparam logic [15:0] READ_ARRAY_CMD   = 16'h00FF;
  localparam int          SUPPLY_ERROR_BIT = 3;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_WDATA    = 8'h08;
  localparam logic [7:0] REG_RDATA    = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_ARRAY_BIT = 4;
  localparam int CTRL_WP_BIT    = 8;
  localparam int WDATA_CMD_LSB  = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DOWN_BIT  = 1;
  localparam int STAT_STALE_BIT = 2;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_REFUSE_BIT = 1;
  localparam int IRQ_ERROR_BIT  = 2;
  localparam logic       WP_N_RESET     = 1'b0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ==========================================================
  // Operation codes
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_CMD2  = 3'h3;
  localparam logic [2:0] OP_SLEEP = 3'h4;
  localparam logic [2:0] OP_WAKE  = 3'h5;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_READ  = 6'b00_0010,
    ST_WLOW  = 6'b00_0100,
    ST_WHIGH = 6'b00_1000,
    ST_DOWN  = 6'b01_0000,
    ST_WAKE  = 6'b10_0000
  } fpc_state_e_t;

endpackage

// File: fpc_sync.sv
`timescale 1ns/10ps
module fpc_sync
  import fpc_pkg::*;
(
  input  logic              clk_i,
  input  logic              rst_i,
  input  logic [DATA_W-1:0] d_i,
  output logic [DATA_W-1:0] q_o
);

  typedef struct packed {
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic [DATA_W-1:0] q;
  } fpc_sync_t;

  fpc_sync_t cur_ff;
  fpc_sync_t nxt_ff;

  always_comb
  begin
    nxt_ff    = cur_ff;
    nxt_ff.s1 = d_i;
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.s3 = cur_ff.s2;
    // Only a settled value is passed on
    if (cur_ff.s2 == cur_ff.s3)
    begin
      nxt_ff.q = cur_ff.s3;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign q_o = cur_ff.q;

endmodule

// File: fpc_timer.sv
`timescale 1ns/10ps
module fpc_timer
  import fpc_pkg::*;
(
  input  logic             clk_i,
  input  logic             rst_i,
  input  logic             load_i,
  input  logic [TMR_W-1:0] count_i,
  output logic             expired_o
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } fpc_timer_t;

  fpc_timer_t cur_ff;
  fpc_timer_t nxt_ff;

  always_comb
  begin
    nxt_ff = cur_ff;
    if (load_i)
    begin
      nxt_ff.cnt = count_i;
    end
    else if (cur_ff.cnt != '0)
    begin
      nxt_ff.cnt = cur_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign expired_o = (cur_ff.cnt == '0);

endmodule

// File: fpc_ctrl.sv
//
// Overview of operation
// - Wait recovery time after power-down release
// - Writes only with strobe and select low
// - Issue read-array before array reads after program
// - Drive reset/power-down from system reset
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module fpc_ctrl
  import fpc_pkg::*;
(
  input  logic              clk_i,
  input  logic              rst_i,
  input  logic              wb_cyc_i,
  input  logic              wb_stb_i,
  input  logic              wb_we_i,
  input  logic [7:0]        wb_adr_i,
  input  logic [3:0]        wb_sel_i,
  input  logic [31:0]       wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              irq_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  input  logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic              flash_dq_oe_o,
  output logic              flash_ce_n_o,
  output logic              flash_oe_n_o,
  output logic              flash_we_n_o,
  output logic              flash_wp_n_o,
  output logic              reset_powerdown_n_o
);

  // ==========================================================
  // State
  typedef struct packed {
    fpc_state_e_t      st;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rp_n;
    logic              wp_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe;
    logic [31:0]       wdata;
    logic [2:0]        op;
    logic              arr;
    logic              phase;
    logic              stale;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        irq_stat;
    logic [2:0]        irq_mask;
    logic              irq;
    logic              ack;
    logic [31:0]       dat;
  } fpc_ctrl_t;

  fpc_ctrl_t         cur_ff;
  fpc_ctrl_t         nxt_ff;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_cnt;
  logic              tmr_expired;
  logic [DATA_W-1:0] dq_sync;
  logic              req;
  logic              start;
  logic [2:0]        start_op;
  logic [2:0]        irq_set;
  logic [2:0]        irq_clr;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [TMR_W-1:0] cyc(input int n);
    return TMR_W'(n);
  endfunction

  fpc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (flash_dq_i),
    .q_o   (dq_sync)
  );

  fpc_timer u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (tmr_load),
    .count_i   (tmr_cnt),
    .expired_o (tmr_expired)
  );

  assign req      = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
  assign start_op = wb_dat_i[CTRL_OP_LSB +: 3];
  assign start    = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL)
                    & (start_op != OP_NONE);

  always_comb
  begin
    nxt_ff   = cur_ff;
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    irq_set  = '0;
    irq_clr  = '0;
    nxt_ff.ack = req;

    // ========================================================
    // Register bus slave
    if (req)
    begin
      nxt_ff.dat = '0;
      if (wb_we_i)
      begin
        if (wb_adr_i == REG_CTRL)
        begin
          if (wb_sel_i[1])
          begin
            nxt_ff.wp_n = wb_dat_i[CTRL_WP_BIT];
          end
        end
        else if (wb_adr_i == REG_ADDR)
        begin
          nxt_ff.addr = ADDR_W'(merge_lanes(32'(cur_ff.addr), wb_dat_i, wb_sel_i));
        end
        else if (wb_adr_i == REG_WDATA)
        begin
          nxt_ff.wdata = merge_lanes(cur_ff.wdata, wb_dat_i, wb_sel_i);
        end
        else if (wb_adr_i == REG_IRQ_STAT)
        begin
          irq_clr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
        end
        else if (wb_adr_i == REG_IRQ_MASK)
        begin
          nxt_ff.irq_mask = 3'(merge_lanes(32'(cur_ff.irq_mask), wb_dat_i, wb_sel_i));
        end
      end
      else
      begin
        if (wb_adr_i == REG_CTRL)
        begin
          nxt_ff.dat[CTRL_OP_LSB +: 3]  = cur_ff.op;
          nxt_ff.dat[CTRL_ARRAY_BIT]    = cur_ff.arr;
          nxt_ff.dat[CTRL_WP_BIT]       = cur_ff.wp_n;
        end
        else if (wb_adr_i == REG_ADDR)
        begin
          nxt_ff.dat = 32'(cur_ff.addr);
        end
        else if (wb_adr_i == REG_WDATA)
        begin
          nxt_ff.dat = cur_ff.wdata;
        end
        else if (wb_adr_i == REG_RDATA)
        begin
          nxt_ff.dat = 32'(cur_ff.rdata);
        end
        else if (wb_adr_i == REG_STATUS)
        begin
          nxt_ff.dat[STAT_BUSY_BIT]  = (cur_ff.st != ST_IDLE) && (cur_ff.st != ST_DOWN);
          nxt_ff.dat[STAT_DOWN_BIT]  = (cur_ff.st == ST_DOWN);
          nxt_ff.dat[STAT_STALE_BIT] = cur_ff.stale;
        end
        else if (wb_adr_i == REG_IRQ_STAT)
        begin
          nxt_ff.dat = 32'(cur_ff.irq_stat);
        end
        else if (wb_adr_i == REG_IRQ_MASK)
        begin
          nxt_ff.dat = 32'(cur_ff.irq_mask);
        end
      end
    end

    // ========================================================
    // Flash sequencer
    case (cur_ff.st)
      ST_IDLE:
      begin
        if (start)
        begin
          nxt_ff.op  = start_op;
          nxt_ff.arr = wb_dat_i[CTRL_ARRAY_BIT];
          if (start_op == OP_READ && wb_dat_i[CTRL_ARRAY_BIT] && cur_ff.stale)
          begin
            // Program/erase left the device in status mode
            nxt_ff.stale = 1'b0;
            nxt_ff.dq    = READ_ARRAY_CMD;
            nxt_ff.phase = 1'b0;
            nxt_ff.st    = ST_WLOW;
          end
          else if (start_op == OP_READ)
          begin
            nxt_ff.ce_n = 1'b0;
            nxt_ff.oe_n = 1'b0;
            nxt_ff.st   = ST_READ;
            tmr_load    = 1'b1;
            tmr_cnt     = cyc(READ_CYC);
          end
          else if (start_op == OP_WRITE || start_op == OP_CMD2)
          begin
            nxt_ff.dq    = (start_op == OP_CMD2) ? cur_ff.wdata[WDATA_CMD_LSB +: 16]
                                                 : cur_ff.wdata[15:0];
            nxt_ff.phase = (start_op == OP_CMD2);
            nxt_ff.st    = ST_WLOW;
          end
          else if (start_op == OP_SLEEP)
          begin
            nxt_ff.rp_n  = 1'b0;
            nxt_ff.stale = 1'b0;
            nxt_ff.st    = ST_DOWN;
            irq_set[IRQ_DONE_BIT] = 1'b1;
          end
          else
          begin
            irq_set[IRQ_REFUSE_BIT] = 1'b1;
          end
          if (nxt_ff.st == ST_WLOW)
          begin
            // Both strobes low together, data driven
            nxt_ff.ce_n  = 1'b0;
            nxt_ff.we_n  = 1'b0;
            nxt_ff.dq_oe = 1'b1;
            tmr_load     = 1'b1;
            tmr_cnt      = cyc(WE_LOW_CYC);
          end
        end
      end

      ST_WLOW:
      begin
        if (tmr_expired)
        begin
          nxt_ff.we_n = 1'b1;
          nxt_ff.ce_n = 1'b1;
          nxt_ff.st   = ST_WHIGH;
          tmr_load    = 1'b1;
          tmr_cnt     = cyc(WE_HIGH_CYC);
        end
      end

      ST_WHIGH:
      begin
        if (tmr_expired)
        begin
          nxt_ff.dq_oe = 1'b0;
          if (cur_ff.op == OP_CMD2 && cur_ff.phase)
          begin
            // Second half of the command pair
            nxt_ff.phase = 1'b0;
            nxt_ff.dq    = cur_ff.wdata[15:0];
            nxt_ff.dq_oe = 1'b1;
            nxt_ff.ce_n  = 1'b0;
            nxt_ff.we_n  = 1'b0;
            nxt_ff.st    = ST_WLOW;
            tmr_load     = 1'b1;
            tmr_cnt      = cyc(WE_LOW_CYC);
          end
          else if (cur_ff.op == OP_READ)
          begin
            nxt_ff.ce_n = 1'b0;
            nxt_ff.oe_n = 1'b0;
            nxt_ff.st   = ST_READ;
            tmr_load    = 1'b1;
            tmr_cnt     = cyc(READ_CYC);
          end
          else
          begin
            // Device now reports status until told otherwise
            if (cur_ff.op == OP_CMD2)
            begin
              nxt_ff.stale = 1'b1;
            end
            nxt_ff.st = ST_IDLE;
            irq_set[IRQ_DONE_BIT] = 1'b1;
          end
        end
      end

      ST_READ:
      begin
        if (tmr_expired)
        begin
          nxt_ff.rdata = dq_sync;
          nxt_ff.ce_n  = 1'b1;
          nxt_ff.oe_n  = 1'b1;
          nxt_ff.st    = ST_IDLE;
          irq_set[IRQ_DONE_BIT] = 1'b1;
          if (cur_ff.stale && dq_sync[SUPPLY_ERROR_BIT])
          begin
            irq_set[IRQ_ERROR_BIT] = 1'b1;
          end
        end
      end

      ST_DOWN:
      begin
        if (start && start_op == OP_WAKE)
        begin
          nxt_ff.op    = start_op;
          nxt_ff.rp_n  = 1'b1;
          nxt_ff.phase = 1'b1;
          nxt_ff.st    = ST_WAKE;
          tmr_load     = 1'b1;
          tmr_cnt      = cyc(RECOVERY_CYC);
        end
        else if (start)
        begin
          irq_set[IRQ_REFUSE_BIT] = 1'b1;
        end
      end

      ST_WAKE:
      begin
        if (!cur_ff.phase)
        begin
          // Leaving system reset
          nxt_ff.rp_n  = 1'b1;
          nxt_ff.phase = 1'b1;
          tmr_load     = 1'b1;
          tmr_cnt      = cyc(RECOVERY_CYC);
        end
        else if (tmr_expired)
        begin
          nxt_ff.phase = 1'b0;
          nxt_ff.st    = ST_IDLE;
          irq_set[IRQ_DONE_BIT] = 1'b1;
        end
      end

      default:
      begin
        nxt_ff.st = ST_IDLE;
      end
    endcase

    if (start && cur_ff.st != ST_IDLE && cur_ff.st != ST_DOWN)
    begin
      irq_set[IRQ_REFUSE_BIT] = 1'b1;
    end

    // ========================================================
    // Interrupts: a new event wins over a clear
    nxt_ff.irq_stat = (cur_ff.irq_stat & ~irq_clr) | irq_set;
    nxt_ff.irq      = |(nxt_ff.irq_stat & nxt_ff.irq_mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_ff          <= '0;
      cur_ff.st       <= ST_WAKE;
      cur_ff.ce_n     <= 1'b1;
      cur_ff.oe_n     <= 1'b1;
      cur_ff.we_n     <= 1'b1;
      cur_ff.rp_n     <= 1'b0;
      cur_ff.wp_n     <= WP_N_RESET;
      cur_ff.irq_mask <= IRQ_MASK_RESET;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign wb_dat_o            = cur_ff.dat;
  assign wb_ack_o            = cur_ff.ack;
  assign irq_o               = cur_ff.irq;
  assign flash_addr_o        = cur_ff.addr;
  assign flash_dq_o          = cur_ff.dq;
  assign flash_dq_oe_o       = cur_ff.dq_oe;
  assign flash_ce_n_o        = cur_ff.ce_n;
  assign flash_oe_n_o        = cur_ff.oe_n;
  assign flash_we_n_o        = cur_ff.we_n;
  assign flash_wp_n_o        = cur_ff.wp_n;
  assign reset_powerdown_n_o = cur_ff.rp_n;

endmodule

// File: fpc_ctrl_assertions.sv
`timescale 1ns/10ps
module fpc_ctrl_chk
  import fpc_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic flash_dq_oe_o,
  input logic flash_ce_n_o,
  input logic flash_oe_n_o,
  input logic flash_we_n_o,
  input logic reset_powerdown_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Strobe shapes
  sequence we_pulse_s;
    !flash_we_n_o [*8] ##1 flash_we_n_o;
  endsequence
  sequence rd_pulse_s;
    !flash_oe_n_o [*8] ##1 !flash_oe_n_o [*6] ##1 flash_oe_n_o;
  endsequence
  sequence recover_s;
    flash_ce_n_o [*8] ##1 flash_ce_n_o [*7];
  endsequence
  // ==========================================================
  // Bus and pin relations
  ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  write_select_a: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
    else $error("write strobe without select");
  drive_write_a: assert property (flash_dq_oe_o |-> flash_oe_n_o && reset_powerdown_n_o)
    else $error("data driven against flash outputs");
  down_quiet_a: assert property (!reset_powerdown_n_o |->
    flash_ce_n_o && flash_we_n_o && flash_oe_n_o && !flash_dq_oe_o)
    else $error("strobes active in power-down");
  recovery_wait_a: assert property ($rose(reset_powerdown_n_o) |-> recover_s)
    else $error("access before recovery time");
  we_width_a: assert property ($fell(flash_we_n_o) |-> we_pulse_s)
    else $error("write strobe width wrong");
  read_width_a: assert property ($fell(flash_oe_n_o) |-> rd_pulse_s)
    else $error("read strobe width wrong");
  reset_down_a: assert property (disable iff (1'b0) rst_i |=> !reset_powerdown_n_o)
    else $error("flash not held in reset with system");
endmodule

// File: fpc_flash_model.sv
`timescale 1ns/10ps
module fpc_flash_model
  import fpc_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LOCK_TOP = 20'h0_1000
)
(
  input  logic              ce_n_i,
  input  logic              oe_n_i,
  input  logic              we_n_i,
  input  logic              wp_n_i,
  input  logic              rpd_n_i,
  input  logic              vpp_ok_i,
  input  logic [ADDR_W-1:0] addr_i,
  input  logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] cmd = '0;
  logic [DATA_W-1:0] val;
  logic [7:0]        sr  = '0;
  logic              arr = 1'b1;
  wire               wr_n = we_n_i | ce_n_i;
  initial
    foreach (mem[i]) mem[i] = 16'hFFFF;
  // ==========================================================
  // Command interface, latched when either strobe rises
  always @(posedge wr_n or negedge rpd_n_i)
  begin
    if (!rpd_n_i)
    begin
      sr  = '0;
      arr = 1'b1;
      cmd = '0;
    end
    else if (cmd == 16'h0040)
    begin
      if (!vpp_ok_i)
        sr[3] = 1'b1;
      else if (!wp_n_i && addr_i < LOCK_TOP)
        sr[4] = 1'b1;
      else
        mem[addr_i[7:0]] = dq_i;
      cmd = '0;
      arr = 1'b0;
    end
    else
    begin
      cmd = dq_i;
      if (dq_i == READ_ARRAY_CMD || dq_i == 16'h0040 || dq_i == 16'h0070)
        arr = (dq_i == READ_ARRAY_CMD);
    end
  end
  // Floating bus shows the inverted value, never the last data
  always @*
  begin
    val = arr ? mem[addr_i[7:0]] : {8'h00, sr | 8'h80};
    dq_o = (rpd_n_i && !ce_n_i && !oe_n_i) ? val : ~val;
  end
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import fpc_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = '0;
  logic [3:0]        wb_sel_i = 4'hF;
  logic [31:0]       wb_dat_i = '0;
  logic [31:0]       wb_dat_o, rdat;
  logic              wb_ack_o, irq_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o;
  logic              flash_we_n_o, flash_wp_n_o, reset_powerdown_n_o;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [DATA_W-1:0] flash_dq_i, flash_dq_o, mdl_dq;
  logic              vpp_ok = 1'b1;
  logic              wp_n = 1'b0;
  int                error_cnt = 0;
  int                total_checks = 0;
  assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : mdl_dq;
  always #5 clk_i = ~clk_i;
  fpc_ctrl fpc_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .flash_addr_o, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_wp_n_o,
    .reset_powerdown_n_o);
  fpc_flash_model fpc_flash_model_i (.ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o), .wp_n_i(flash_wp_n_o), .rpd_n_i(reset_powerdown_n_o),
    .vpp_ok_i(vpp_ok), .addr_i(flash_addr_o), .dq_i(flash_dq_i), .dq_o(mdl_dq));
  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(nm, e, rdat);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    rdat = '0;
    while (rdat[IRQ_DONE_BIT] !== 1'b1 && n < 200)
    begin
      bus(1'b0, REG_IRQ_STAT, '0);
      n++;
    end
    chk("done", 32'h0000_0001, {31'h0, rdat[IRQ_DONE_BIT]});
    bus(1'b1, REG_IRQ_STAT, 32'h0000_0001);
  endtask
  task automatic run(input logic [2:0] op, input logic a);
    bus(1'b1, REG_CTRL, {23'h0, wp_n, 3'h0, a, 1'b0, op});
    wait_done();
  endtask
  task automatic prog(input logic [19:0] a, input logic [15:0] d);
    bus(1'b1, REG_ADDR, {12'h000, a});
    bus(1'b1, REG_WDATA, {16'h0040, d});
    run(OP_CMD2, 1'b0);
  endtask
  task automatic rd(input logic [19:0] a, input logic arr);
    bus(1'b1, REG_ADDR, {12'h000, a});
    run(OP_READ, arr);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    wait_done();
    chk("rpd pin", 32'h0000_0001, {31'h0, reset_powerdown_n_o});
    rchk("mask", REG_IRQ_MASK, 32'h0000_0000);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h1C, 32'h0000_0000);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    rchk("status", REG_STATUS, 32'h0000_0000);
  endtask
  task automatic t_prog;
    prog(20'h0_2000, 16'h1234);
    rchk("stale", REG_STATUS, 32'h0000_0004);
    rd(20'h0_2000, 1'b1);
    rchk("rdata", REG_RDATA, 32'h0000_1234);
    rchk("clean", REG_STATUS, 32'h0000_0000);
  endtask
  task automatic t_locked;
    prog(20'h0_0010, 16'hBEEF);
    rd(20'h0_0010, 1'b0);
    rchk("lock err", REG_RDATA, 32'h0000_0090);
    wp_n = 1'b1;
    rd(20'h0_0010, 1'b1);
    rchk("locked", REG_RDATA, 32'h0000_FFFF);
    chk("wp pin", 32'h0000_0001, {31'h0, flash_wp_n_o});
    prog(20'h0_0010, 16'hBEEF);
    rd(20'h0_0010, 1'b1);
    rchk("unlocked", REG_RDATA, 32'h0000_BEEF);
  endtask
  task automatic t_supply;
    vpp_ok <= 1'b0;
    prog(20'h0_2001, 16'h5555);
    rd(20'h0_2001, 1'b0);
    rchk("err stat", REG_IRQ_STAT, 32'h0000_0004);
    chk("masked", 32'h0000_0000, {31'h0, irq_o});
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    chk("irq", 32'h0000_0001, {31'h0, irq_o});
    bus(1'b1, REG_IRQ_STAT, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    chk("irq clr", 32'h0000_0000, {31'h0, irq_o});
    vpp_ok <= 1'b1;
    rd(20'h0_2001, 1'b1);
    rchk("no prog", REG_RDATA, 32'h0000_FFFF);
  endtask
  task automatic t_sleep;
    run(OP_SLEEP, 1'b0);
    chk("rpd low", 32'h0000_0000, {31'h0, reset_powerdown_n_o});
    rchk("down", REG_STATUS, 32'h0000_0002);
    bus(1'b1, REG_CTRL, {23'h0, wp_n, 3'h0, 1'b0, 1'b0, OP_READ});
    rchk("refused", REG_IRQ_STAT, 32'h0000_0002);
    chk("ce idle", 32'h0000_0001, {31'h0, flash_ce_n_o});
    bus(1'b1, REG_IRQ_STAT, 32'h0000_0002);
    run(OP_WAKE, 1'b0);
    rd(20'h0_2000, 1'b0);
    rchk("array", REG_RDATA, 32'h0000_1234);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prog();
    t_locked();
    t_supply();
    t_sleep();
    stop_test();
  end
  initial
  begin
    #200_000;
    error_cnt++;
    stop_test();
  end
endmodule
bind fpc_ctrl fpc_ctrl_chk fpc_ctrl_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_dq_oe_o(flash_dq_oe_o),
  .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .reset_powerdown_n_o(reset_powerdown_n_o));
